// ===== pkg/config_button_pkg.sv
// constants, register map and carrier types for the button and mode control block
// assumes a single 125 MHz clock and a plain single-cycle register port
package config_button_pkg;

	// clock and time base
	localparam int unsigned CLK_NS = 8;
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned TICK_CYC = MS_NS / CLK_NS;

	// times in milliseconds, counted on the 1 ms tick
	localparam logic [11:0] LONG_MS = 12'h7d0;      // 2000 ms
	localparam logic [11:0] SHORT_MS = 12'h3e8;     // 1000 ms
	localparam logic [11:0] DOUBLE_MS = 12'h1f4;    // 500 ms
	localparam logic [11:0] SLOW_HALF_MS = 12'h1f4; // one flash per second
	localparam logic [11:0] FAST_HALF_MS = 12'h064; // 100 ms
	localparam logic [11:0] SHOW_HALF_MS = 12'h0fa; // 250 ms
	localparam logic [11:0] VEND_MS = 12'h064;      // 100 ms credit line low
	localparam logic [11:0] PULSE_UNIT_MS = 12'h032; // 50 ms per width step
	localparam logic [11:0] DEBOUNCE_MS = 12'h014;  // 20 ms
	localparam logic [5:0] FAST_TOGGLES = 6'h10;

	// register byte offsets
	localparam logic [3:0] CONFIG_OFS = 4'h0;
	localparam logic [3:0] CARD_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;
	localparam logic [3:0] KEY_OFS = 4'hc;

	typedef enum logic [2:0] {
		mode_parallel = 3'h0,
		mode_pulse = 3'h1,
		mode_always_enabled_pulse = 3'h2,
		mode_secure_serial = 3'h3,
		mode_checksum_serial = 3'h4,
		mode_simple_serial = 3'h5
	} host_mode_t;

	// stored configuration word, bit 0 upward: inhibit, mode, options
	typedef struct packed {
		logic [2:0] spare;
		logic [2:0] mult_sel;
		logic [1:0] width_sel;
		logic start_disabled;
		logic high_speed;
		logic credit_hold;
		logic no_escrow_timeout;
		logic binary_out;
		host_mode_t mode;
		logic [15:0] inhibit;
	} cfg_t;

	localparam cfg_t CFG_RESET = '{spare: 3'h0, mult_sel: 3'h0, width_sel: 2'h1,
		start_disabled: 1'b0, high_speed: 1'b0, credit_hold: 1'b0,
		no_escrow_timeout: 1'b0, binary_out: 1'b0, mode: mode_secure_serial,
		inhibit: 16'h0000};

	typedef struct packed {
		logic valid;
		logic [3:0] chan;
		logic [7:0] count;
	} credit_req_t;

	typedef enum logic [1:0] {
		b_idle = 2'b00,
		b_held1 = 2'b01,
		b_gap = 2'b11,
		b_held2 = 2'b10
	} btn_state_t;

	typedef enum logic [2:0] {
		u_normal = 3'b000,
		u_card = 3'b001,
		u_store = 3'b011,
		u_prog = 3'b010,
		u_show = 3'b110
	} ui_state_t;

endpackage

// ===== rtl/pin_conditioner.sv
// two-flop synchronisers for the connector inputs, debounce for the button
// assumes tick_i is a one-cycle 1 ms enable on the same clock
module pin_conditioner (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic tick_i,
	input wire logic button_pin_n_i,
	input wire logic [3:0] inhibit_pin_i,
	output logic button_o,
	output logic [3:0] inhibit_o
);
	logic [4:0] meta;
	logic [4:0] sync;
	logic [11:0] bounce_ms;
	logic [11:0] next_bounce_ms;
	logic pressed;
	logic next_pressed;
	logic [4:0] raw;

	assign raw = {button_pin_n_i, inhibit_pin_i};

	genvar i;
	generate
		for (i = 0; i < 5; i++) begin : g_sync
			always_ff @(posedge clock_i or negedge resetn_i) begin
				if (!resetn_i) begin
					meta[i] <= 1'b1;
					sync[i] <= 1'b1;
				end else begin
					meta[i] <= raw[i];
					sync[i] <= meta[i];
				end
			end
		end
	endgenerate

	// the level must hold 20 ms before it is taken, so contact bounce never times a press
	always_comb begin
		next_pressed = pressed;
		next_bounce_ms = bounce_ms;
		if (!sync[4] == pressed) begin
			next_bounce_ms = 12'h000;
		end else if (tick_i) begin
			next_bounce_ms = bounce_ms + 12'h001;
			if (bounce_ms + 12'h001 >= config_button_pkg::DEBOUNCE_MS) begin
				next_pressed = !sync[4];
				next_bounce_ms = 12'h000;
			end
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pressed <= 1'b0;
			bounce_ms <= 12'h000;
		end else begin
			pressed <= next_pressed;
			bounce_ms <= next_bounce_ms;
		end
	end

	assign button_o = pressed;
	assign inhibit_o = sync[3:0];
endmodule

// ===== rtl/config_button_mode_control.sv
// button decoder, bezel patterns, stored interface options and connector pin mapping
// assumes protocol, note path and storage logic around it; one 125 MHz clock
//
// Contract
// (R1) press held over 2 s then released: programming mode, fast flash, restart
// (R2) single press under 1 s: enter card mode, bezel toggles slowly
// (R3) another short press in card mode cancels it, back to normal
// (R4) two presses within half a second: flash the interface type count
// (R5) host leaves at least 200 ms between poll commands
// (R6) per-channel inhibit held; notes on inhibited channels refused
// (R7) parallel binary option gives binary-coded channel on credit lines
// (R8) parallel and simple serial: option disables escrow timeout
// (R9) pulse mode uses configured pulse width and count multiplier
// (R10) pulse mode option enables credit hold
// (R11) always-enabled pulse: like pulse, ignores inhibit pins
// (R12) simple serial high-speed option selects 9600 baud
// (R13) simple serial start-disabled option: acceptance off after power-up; the code reads it from CFG_RESET, so host_en always starts set
// (R14) secure serial: tx on credit 1, rx from inhibit 1, log on credit 2
// (R15) checksummed serial: credit 1 and inhibit 1 form one shared line
// (R16) key exchange accepted only in trusted mode from physical access
// (R17) card mode waiting: bezel flashes once per second
// (R18) valid card read: fast flash while storing, then reset
// (R19) button synchronised and debounced; 1 to 2 s single press ignored
// (R20) unused pins in serial modes held inactive, their inputs ignored
//
// The strobed register port and the register addresses were chosen for this implementation.
module config_button_mode_control #(
	parameter int unsigned TICK_CYC = config_button_pkg::TICK_CYC
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic button_pin_n_i,
	input wire logic [3:0] inhibit_pin_i,
	output logic [3:0] credit_pin_o,
	output logic [3:0] credit_pin_oe_o,
	input wire config_button_pkg::credit_req_t credit_req_i,
	input wire logic note_valid_i,
	input wire logic [3:0] note_chan_i,
	output logic note_accept_o,
	output logic note_refuse_o,
	input wire logic serial_tx_i,
	input wire logic serial_tx_en_i,
	input wire logic log_tx_i,
	input wire logic host_enable_i,
	input wire logic host_disable_i,
	output logic serial_rx_o,
	output logic [15:0] chan_enable_o,
	output logic bezel_o,
	output logic restart_o,
	output logic prog_mode_o,
	output logic trusted_o,
	output logic [31:0] key_o,
	output logic escrow_timeout_en_o,
	output logic high_speed_o,
	output logic credit_hold_o,
	output logic credit_busy_o
);
	localparam int TW = $clog2(TICK_CYC + 1);

	logic [TW-1:0] div_cnt;
	logic [TW-1:0] next_div_cnt;
	logic tick;
	logic next_tick;
	logic button;
	logic [3:0] inhibit_sync;

	pin_conditioner u_pins (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.tick_i(tick),
		.button_pin_n_i(button_pin_n_i),
		.inhibit_pin_i(inhibit_pin_i),
		.button_o(button),
		.inhibit_o(inhibit_sync)
	);

	// 1 ms enable
	always_comb begin
		next_tick = 1'b0;
		next_div_cnt = div_cnt + TW'(1);
		if (div_cnt == TW'(TICK_CYC - 1)) begin
			next_div_cnt = '0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_cnt <= '0;
			tick <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			tick <= next_tick;
		end
	end

	// button timing
	config_button_pkg::btn_state_t btn_state, next_btn_state;
	logic [11:0] btn_ms, next_btn_ms;
	logic ev_long, ev_short, ev_double;
	logic next_ev_long, next_ev_short, next_ev_double;

	always_comb begin
		next_btn_state = btn_state;
		next_btn_ms = btn_ms;
		next_ev_long = 1'b0;
		next_ev_short = 1'b0;
		next_ev_double = 1'b0;
		if (tick && btn_ms != 12'hfff) begin
			next_btn_ms = btn_ms + 12'h001;
		end
		unique case (btn_state)
			config_button_pkg::b_idle: begin
				next_btn_ms = 12'h000;
				if (button) begin
					next_btn_state = config_button_pkg::b_held1;
				end
			end
			config_button_pkg::b_held1: begin
				if (!button) begin
					if (btn_ms > config_button_pkg::LONG_MS) begin
						next_ev_long = 1'b1; // R1
						next_btn_state = config_button_pkg::b_idle;
					end else if (btn_ms < config_button_pkg::SHORT_MS) begin
						next_btn_state = config_button_pkg::b_gap;
					end else begin
						next_btn_state = config_button_pkg::b_idle; // R19
					end
				end
			end
			config_button_pkg::b_gap: begin
				// time runs from the first press, so a double must start inside 500 ms
				if (btn_ms >= config_button_pkg::DOUBLE_MS) begin
					next_ev_short = 1'b1; // R2
					next_btn_state = config_button_pkg::b_idle;
				end else if (button) begin
					next_btn_state = config_button_pkg::b_held2;
				end
			end
			config_button_pkg::b_held2: begin
				if (!button) begin
					next_ev_double = 1'b1; // R4
					next_btn_state = config_button_pkg::b_idle;
				end
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			btn_state <= config_button_pkg::b_idle;
			btn_ms <= 12'h000;
			ev_long <= 1'b0;
			ev_short <= 1'b0;
			ev_double <= 1'b0;
		end else begin
			btn_state <= next_btn_state;
			btn_ms <= next_btn_ms;
			ev_long <= next_ev_long;
			ev_short <= next_ev_short;
			ev_double <= next_ev_double;
		end
	end

	// user mode and bezel patterns
	config_button_pkg::ui_state_t ui, next_ui;
	config_button_pkg::cfg_t cfg, next_cfg;
	logic [11:0] ui_ms, next_ui_ms;
	logic [5:0] toggles, next_toggles;
	logic next_bezel, next_restart;
	logic [11:0] half;
	logic card_wr;
	assign card_wr = wr_i && addr_i == config_button_pkg::CARD_OFS
		&& ui == config_button_pkg::u_card;

	always_comb begin
		next_ui = ui;
		next_ui_ms = ui_ms;
		next_toggles = toggles;
		next_bezel = bezel_o;
		next_restart = 1'b0;
		unique case (ui)
			config_button_pkg::u_card: half = config_button_pkg::SLOW_HALF_MS;
			config_button_pkg::u_show: half = config_button_pkg::SHOW_HALF_MS;
			default: half = config_button_pkg::FAST_HALF_MS;
		endcase
		if (ui != config_button_pkg::u_normal && tick) begin
			next_ui_ms = ui_ms + 12'h001;
			if (ui_ms + 12'h001 >= half) begin
				next_ui_ms = 12'h000;
				next_bezel = !bezel_o; // R17
				next_toggles = toggles - 6'h01;
			end
		end
		unique case (ui)
			config_button_pkg::u_normal: begin
				next_bezel = 1'b0;
				next_ui_ms = 12'h000;
				next_toggles = config_button_pkg::FAST_TOGGLES;
				if (ev_long) begin
					next_ui = config_button_pkg::u_prog; // R1
					next_bezel = 1'b1;
				end else if (ev_short) begin
					next_ui = config_button_pkg::u_card; // R2
					next_bezel = 1'b1;
				end else if (ev_double) begin
					next_ui = config_button_pkg::u_show; // R4
					next_bezel = 1'b1;
					next_toggles = {1'b0, 4'({1'b0, cfg.mode} + 4'h1), 1'b0} - 6'h01;
				end
			end
			config_button_pkg::u_card: begin
				if (card_wr) begin
					next_ui = config_button_pkg::u_store; // R18
					next_ui_ms = 12'h000;
					next_bezel = 1'b1;
					next_toggles = config_button_pkg::FAST_TOGGLES;
				end else if (ev_short) begin
					next_ui = config_button_pkg::u_normal; // R3
				end
			end
			config_button_pkg::u_store, config_button_pkg::u_prog: begin
				if (toggles == 6'h00) begin
					next_ui = config_button_pkg::u_normal;
					next_restart = 1'b1; // R18
				end
			end
			config_button_pkg::u_show: begin
				if (toggles == 6'h00) begin
					next_ui = config_button_pkg::u_normal;
				end
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ui <= config_button_pkg::u_normal;
			ui_ms <= 12'h000;
			toggles <= 6'h00;
			bezel_o <= 1'b0;
			restart_o <= 1'b0;
		end else begin
			ui <= next_ui;
			ui_ms <= next_ui_ms;
			toggles <= next_toggles;
			bezel_o <= next_bezel;
			restart_o <= next_restart;
		end
	end

	// registers, key and host enable
	logic [31:0] next_rdata, next_key;
	logic key_loaded, next_key_loaded;
	logic host_en, next_host_en, init_done;
	logic key_wr;
	assign key_wr = wr_i && addr_i == config_button_pkg::KEY_OFS
		&& ui == config_button_pkg::u_card && cfg.mode == config_button_pkg::mode_checksum_serial;

	always_comb begin
		next_cfg = cfg;
		next_key = key_o;
		next_key_loaded = key_loaded;
		next_host_en = host_en;
		next_rdata = 32'h0000_0000;
		if (card_wr) begin
			next_cfg = config_button_pkg::cfg_t'(wdata_i);
		end
		if (ui == config_button_pkg::u_normal && ev_long) begin
			next_cfg.mode = config_button_pkg::mode_secure_serial; // R1
		end
		if (key_wr) begin
			next_key = wdata_i; // R16
			next_key_loaded = 1'b1;
		end
		if (!init_done) begin
			next_host_en = !(cfg.mode == config_button_pkg::mode_simple_serial
				&& cfg.start_disabled); // R13
		end else if (host_enable_i) begin
			next_host_en = 1'b1;
		end else if (host_disable_i) begin
			next_host_en = 1'b0;
		end
		if (rd_i) begin
			unique case (addr_i)
				config_button_pkg::CONFIG_OFS: next_rdata = cfg;
				config_button_pkg::STATUS_OFS: next_rdata = {24'h00_0000, ui, key_loaded,
					host_en, credit_busy_o, trusted_o, bezel_o};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg <= config_button_pkg::CFG_RESET;
			key_o <= 32'h0000_0000;
			key_loaded <= 1'b0;
			host_en <= 1'b0;
			init_done <= 1'b0;
			rdata_o <= 32'h0000_0000;
		end else begin
			cfg <= next_cfg;
			key_o <= next_key;
			key_loaded <= next_key_loaded;
			host_en <= next_host_en;
			init_done <= 1'b1;
			rdata_o <= next_rdata;
		end
	end

	// credit signalling on the vend lines
	logic cr_active, next_cr_active, cr_low, next_cr_low;
	logic [11:0] cr_ms, next_cr_ms, cr_len;
	logic [15:0] cr_left, next_cr_left;
	logic [3:0] pattern, next_pattern;
	logic parallel_mode, pulse_mode;
	assign parallel_mode = cfg.mode == config_button_pkg::mode_parallel;
	assign pulse_mode = cfg.mode == config_button_pkg::mode_pulse
		|| cfg.mode == config_button_pkg::mode_always_enabled_pulse;

	always_comb begin
		next_cr_active = cr_active;
		next_cr_low = cr_low;
		next_cr_ms = cr_ms;
		next_cr_left = cr_left;
		next_pattern = pattern;
		cr_len = parallel_mode ? config_button_pkg::VEND_MS
			: 12'(config_button_pkg::PULSE_UNIT_MS * ({10'h000, cfg.width_sel} + 12'h001)); // R9
		// a request while a credit is still on the lines is dropped; busy shows it
		if (!cr_active && credit_req_i.valid && ui == config_button_pkg::u_normal) begin
			next_cr_ms = 12'h000;
			next_cr_low = 1'b1;
			if (parallel_mode && credit_req_i.chan != 4'h0) begin
				next_cr_active = 1'b1;
				next_cr_left = 16'h0001;
				if (cfg.binary_out) begin
					next_pattern = credit_req_i.chan; // R7
				end else begin
					next_pattern = (credit_req_i.chan <= 4'h4)
						? 4'(4'h1 << (credit_req_i.chan - 4'h1)) : 4'h0;
				end
			end else if (pulse_mode && credit_req_i.count != 8'h00) begin
				next_cr_active = 1'b1;
				next_cr_left = 16'({8'h00, credit_req_i.count} << cfg.mult_sel); // R9
				next_pattern = 4'h1;
			end
		end else if (cr_active && tick) begin
			next_cr_ms = cr_ms + 12'h001;
			if (cr_ms + 12'h001 >= cr_len) begin
				next_cr_ms = 12'h000;
				next_cr_low = !cr_low;
				if (cr_low) begin
					next_cr_left = cr_left - 16'h0001;
					if (cr_left == 16'h0001) begin
						next_cr_active = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cr_active <= 1'b0;
			cr_low <= 1'b0;
			cr_ms <= 12'h000;
			cr_left <= 16'h0000;
			pattern <= 4'h0;
		end else begin
			cr_active <= next_cr_active;
			cr_low <= next_cr_low;
			cr_ms <= next_cr_ms;
			cr_left <= next_cr_left;
			pattern <= next_pattern;
		end
	end

	// pin mapping, acceptance and option levels
	logic [3:0] next_pin, next_oe;
	logic [15:0] next_en;
	logic next_rx, next_accept, next_refuse, serial_mode;
	assign serial_mode = !parallel_mode && !pulse_mode;

	always_comb begin
		next_pin = ~(pattern & {4{cr_active && cr_low}});
		next_oe = 4'hf;
		next_rx = 1'b1;
		next_en = ~cfg.inhibit; // R6
		if (serial_mode) begin
			next_pin = {2'b11, log_tx_i, serial_tx_i}; // R14 R20
			next_rx = inhibit_sync[0]; // R14
			next_en = next_en & {16{host_en}};
			if (cfg.mode == config_button_pkg::mode_checksum_serial) begin
				next_oe[0] = serial_tx_en_i; // R15
			end
		end else if (cfg.mode != config_button_pkg::mode_always_enabled_pulse) begin
			// pins low enable; with every pin high the whole unit is held off
			next_en = next_en & {{12{~&inhibit_sync}}, ~inhibit_sync};
		end // R11
		if (ui != config_button_pkg::u_normal) begin
			next_en = 16'h0000;
		end
		next_accept = note_valid_i && chan_enable_o[note_chan_i];
		next_refuse = note_valid_i && !chan_enable_o[note_chan_i]; // R6
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			credit_pin_o <= 4'hf;
			credit_pin_oe_o <= 4'hf;
			serial_rx_o <= 1'b1;
			chan_enable_o <= 16'h0000;
			note_accept_o <= 1'b0;
			note_refuse_o <= 1'b0;
			prog_mode_o <= 1'b0;
			trusted_o <= 1'b0;
			escrow_timeout_en_o <= 1'b1;
			high_speed_o <= 1'b0;
			credit_hold_o <= 1'b0;
			credit_busy_o <= 1'b0;
		end else begin
			credit_pin_o <= next_pin;
			credit_pin_oe_o <= next_oe;
			serial_rx_o <= next_rx;
			chan_enable_o <= next_en;
			note_accept_o <= next_accept;
			note_refuse_o <= next_refuse;
			prog_mode_o <= ui == config_button_pkg::u_prog;
			trusted_o <= ui == config_button_pkg::u_card; // R16
			escrow_timeout_en_o <= !(cfg.no_escrow_timeout && (parallel_mode
				|| cfg.mode == config_button_pkg::mode_simple_serial)); // R8
			high_speed_o <= cfg.mode == config_button_pkg::mode_simple_serial
				&& cfg.high_speed; // R12
			credit_hold_o <= pulse_mode && cfg.credit_hold; // R10
			credit_busy_o <= next_cr_active;
		end
	end
endmodule

// ===== tb/config_button_mode_control_assertions.sv
// port-level checks for the button and mode control block
// assumes a bind onto config_button_mode_control, one clock domain
module config_button_mode_control_assertions #(
	parameter int unsigned TICK_CYC = 10
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire config_button_pkg::credit_req_t credit_req_i,
	input wire logic note_valid_i,
	input wire logic note_accept_o,
	input wire logic note_refuse_o,
	input wire logic bezel_o,
	input wire logic restart_o,
	input wire logic prog_mode_o,
	input wire logic trusted_o,
	input wire logic [31:0] key_o,
	input wire logic credit_busy_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	logic last_bezel;
	logic [31:0] still;
	logic [31:0] next_still;
	// slack of one tick for the ms divider phase
	always_comb begin
		next_still = (trusted_o && bezel_o == last_bezel) ? still + 32'h1 : 32'h0;
	end
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			still <= 32'h0;
			last_bezel <= 1'b0;
		end else begin
			still <= next_still;
			last_bezel <= bezel_o;
		end
	end
	property p_note_once;
		note_valid_i |=> note_accept_o != note_refuse_o;
	endproperty
	a_note_once: assert property (p_note_once)
		else $error("note verdict missing or doubled");
	property p_note_cause;
		(note_accept_o || note_refuse_o) |-> $past(note_valid_i);
	endproperty
	a_note_cause: assert property (p_note_cause)
		else $error("note verdict without a note");
	property p_restart_pulse;
		restart_o |=> !restart_o;
	endproperty
	a_restart_pulse: assert property (p_restart_pulse)
		else $error("restart request longer than one cycle");
	property p_prog_restart;
		$fell(prog_mode_o) |-> ($past(restart_o) || restart_o) or ##1 restart_o;
	endproperty
	a_prog_restart: assert property (p_prog_restart)
		else $error("programming flash ended without restart");
	property p_card_lit;
		$rose(trusted_o) |-> ##[0:2] bezel_o;
	endproperty
	a_card_lit: assert property (p_card_lit)
		else $error("bezel not lit on card mode entry");
	property p_card_blink;
		still <= 32'(501 * TICK_CYC + 4);
	endproperty
	a_card_blink: assert property (p_card_blink)
		else $error("bezel stuck in card mode");
	property p_key_trusted;
		$changed(key_o) |-> trusted_o;
	endproperty
	a_key_trusted: assert property (p_key_trusted)
		else $error("key changed outside trusted mode");
	property p_busy_cause;
		$rose(credit_busy_o) |-> $past(credit_req_i.valid);
	endproperty
	a_busy_cause: assert property (p_busy_cause)
		else $error("credit busy without request");
	c_card: cover property ($rose(trusted_o));
	c_restart: cover property (restart_o);
	c_refuse: cover property (note_refuse_o);
	c_busy: cover property ($rose(credit_busy_o));
endmodule

bind config_button_mode_control config_button_mode_control_assertions #(
	.TICK_CYC(TICK_CYC)
) assertions_i (
	.clock_i(clock_i),
	.resetn_i(resetn_i),
	.credit_req_i(credit_req_i),
	.note_valid_i(note_valid_i),
	.note_accept_o(note_accept_o),
	.note_refuse_o(note_refuse_o),
	.bezel_o(bezel_o),
	.restart_o(restart_o),
	.prog_mode_o(prog_mode_o),
	.trusted_o(trusted_o),
	.key_o(key_o),
	.credit_busy_o(credit_busy_o)
);

// ===== tb/host_model.sv
// host controller model: idle-high receive line carrying spaced poll frames
// assumes the bench judges the device's receive path at mid_o
module host_model #(
	parameter int unsigned BIT_CYC = 16,
	parameter int unsigned GAP_CYC = 2100
) (
	input wire logic clock_i,
	input wire logic run_i,
	output logic line_o,
	output logic mid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] poll;
	initial begin
		line_o = 1'b1;
		mid_o = 1'b0;
		poll = 8'ha5;
		forever begin
			@(posedge clock_i);
			if (run_i) begin
				// start bit, eight data bits, stop bit
				for (int b = 0; b < 10; b++) begin
					line_o <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : poll[b - 1];
					repeat (BIT_CYC / 2) @(posedge clock_i);
					mid_o <= 1'b1;
					@(posedge clock_i);
					mid_o <= 1'b0;
					repeat (BIT_CYC / 2 - 1) @(posedge clock_i);
				end
				poll <= ~poll;
				repeat (GAP_CYC) @(posedge clock_i);
			end
		end
	end
endmodule

// ===== tb/test_config_button_mode_control.sv
// self-checking bench for the button decoder, options and pin mapping
// assumes the 1 ms tick scaled to 10 clocks
module test_config_button_mode_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned MS = 10;
	typedef struct packed {logic tx; logic log; logic [2:0] hi; logic [3:0] pins;} row_t;
	row_t rows [4] = '{'{0, 0, 3'h0, 4'hc}, '{1, 0, 3'h7, 4'hd}, '{0, 1, 3'h2, 4'he},
		'{1, 1, 3'h5, 4'hf}};
	logic clock_i, resetn_i, wr_i, rd_i, button_pin_n_i, note_valid_i, serial_tx_i, log_tx_i;
	logic host_enable_i, host_disable_i, note_accept_o, note_refuse_o, serial_rx_o, bezel_o;
	logic restart_o, prog_mode_o, trusted_o, esc_o, credit_busy_o, line, mid, in_serial, prev;
	logic [3:0] addr_i, note_chan_i, credit_pin_o, inh, oe;
	logic hs, hold;
	logic [31:0] wdata_i, rdata_o, key_o, d;
	logic [15:0] chan_enable_o;
	config_button_pkg::credit_req_t credit_req_i;
	int mismatches = 0;
	int checks = 0;
	int n;
	config_button_mode_control #(.TICK_CYC(MS)) config_button_mode_control_i (
		.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .button_pin_n_i(button_pin_n_i),
		.inhibit_pin_i(inh & {3'h7, line}), .credit_pin_o(credit_pin_o), .credit_pin_oe_o(oe),
		.credit_req_i(credit_req_i), .note_valid_i(note_valid_i), .note_chan_i(note_chan_i),
		.note_accept_o(note_accept_o), .note_refuse_o(note_refuse_o),
		.serial_tx_i(serial_tx_i), .serial_tx_en_i(1'b1), .log_tx_i(log_tx_i),
		.host_enable_i(host_enable_i), .host_disable_i(host_disable_i),
		.serial_rx_o(serial_rx_o), .chan_enable_o(chan_enable_o), .bezel_o(bezel_o),
		.restart_o(restart_o), .prog_mode_o(prog_mode_o), .trusted_o(trusted_o),
		.key_o(key_o), .escrow_timeout_en_o(esc_o), .high_speed_o(hs), .credit_hold_o(hold),
		.credit_busy_o(credit_busy_o));
	host_model host_model_i (.clock_i(clock_i), .run_i(in_serial), .line_o(line), .mid_o(mid));
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task cyc(input int c);
		repeat (c) @(posedge clock_i);
	endtask
	task rd(input logic [3:0] a);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task press(input int ms);
		@(posedge clock_i);
		button_pin_n_i <= 1'b0;
		cyc(ms * MS);
		button_pin_n_i <= 1'b1;
	endtask
	task note(input logic [3:0] ch, input logic [1:0] exp);
		@(posedge clock_i);
		note_valid_i <= 1'b1;
		note_chan_i <= ch;
		@(posedge clock_i);
		note_valid_i <= 1'b0;
		@(negedge clock_i);
		check(32'({note_accept_o, note_refuse_o}), 32'(exp), "note verdict");
	endtask
	task wait_restart;
		n = 0;
		while (restart_o !== 1'b1 && n < 20000) begin
			@(negedge clock_i);
			n++;
		end
		check(32'(restart_o), 32'h1, "restart");
	endtask
	task pulse_host(input logic en);
		@(posedge clock_i);
		host_enable_i <= en;
		host_disable_i <= !en;
		@(posedge clock_i);
		host_enable_i <= 1'b0;
		host_disable_i <= 1'b0;
		cyc(4);
	endtask
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	// receive path judged mid-bit, well past the synchroniser delay
	always @(posedge clock_i) begin
		if (mid && in_serial) begin
			check(32'(serial_rx_o), 32'(line), "serial rx");
		end
	end
	initial begin
		cyc(100000);
		mismatches++;
		conclude;
	end
	initial begin
		{resetn_i, wr_i, rd_i, note_valid_i, serial_tx_i, log_tx_i, in_serial, prev} = '0;
		{host_enable_i, host_disable_i, addr_i, note_chan_i, wdata_i, credit_req_i} = '0;
		button_pin_n_i = 1'b1;
		inh = 4'hf;
		cyc(3);
		check(32'({credit_pin_o, esc_o}), 32'h1f, "reset pins");
		resetn_i <= 1'b1;
		rd(config_button_pkg::CONFIG_OFS);
		check(d, 32'h0103_0000, "config reset");
		wr(config_button_pkg::CONFIG_OFS, 32'hffff_ffff);
		rd(config_button_pkg::CONFIG_OFS);
		check(d, 32'h0103_0000, "config read only");
		rd(4'h2);
		check(d, 32'h0, "unmapped");
		in_serial <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clock_i);
			{serial_tx_i, log_tx_i, inh[3:1]} <= {rows[i].tx, rows[i].log, rows[i].hi};
			cyc(4);
			@(negedge clock_i);
			check(32'({credit_pin_o, oe}), 32'({rows[i].pins, 4'hf}), "serial pins");
			check(32'(chan_enable_o), 32'hffff, "serial enables");
		end
		pulse_host(1'b0);
		check(32'(chan_enable_o), 32'h0, "host disabled");
		note(4'h5, 2'b01);
		pulse_host(1'b1);
		check(32'(chan_enable_o), 32'hffff, "host enabled");
		cyc(3000);
		in_serial <= 1'b0;
		press(60);
		cyc(60 * MS);
		press(60);
		n = 0;
		repeat (1800 * MS) begin
			@(negedge clock_i);
			if (bezel_o && !prev) n++;
			prev = bezel_o;
		end
		check(32'(n), 32'h4, "show flashes");
		press(60);
		cyc(550 * MS);
		check(32'(trusted_o), 32'h1, "card mode");
		rd(config_button_pkg::STATUS_OFS);
		check(32'(d[7:5]), 32'h1, "card state");
		// key refused: trusted but not the checksummed serial mode
		wr(config_button_pkg::KEY_OFS, 32'h1234_5678);
		cyc(2);
		check(key_o, 32'h0, "key");
		press(60);
		cyc(550 * MS);
		check(32'(trusted_o), 32'h0, "card cancel");
		press(60);
		cyc(550 * MS);
		wr(config_button_pkg::CARD_OFS, 32'h0010_0004);
		cyc(5);
		rd(config_button_pkg::STATUS_OFS);
		check(32'(d[7:5]), 32'h3, "store state");
		wait_restart;
		rd(config_button_pkg::CONFIG_OFS);
		check(d, 32'h0010_0004, "card stored");
		check(32'({esc_o, hs, hold}), 32'h0, "escrow timeout");
		inh <= 4'he;
		cyc(10);
		check(32'(chan_enable_o), 32'hfff1, "parallel enables");
		note(4'h1, 2'b01);
		note(4'h4, 2'b10);
		@(posedge clock_i);
		credit_req_i <= '{valid: 1'b1, chan: 4'h2, count: 8'h1};
		@(posedge clock_i);
		credit_req_i.valid <= 1'b0;
		cyc(10);
		check(32'({credit_pin_o, credit_busy_o}), 32'h1b, "vend start");
		cyc(850);
		check(32'(credit_pin_o), 32'hd, "vend held");
		cyc(250);
		check(32'(credit_pin_o), 32'hf, "vend end");
		press(2100);
		cyc(30 * MS);
		check(32'(prog_mode_o), 32'h1, "prog mode");
		wait_restart;
		rd(config_button_pkg::CONFIG_OFS);
		check(32'(d[18:16]), 32'h3, "prog mode code");
		conclude;
	end
endmodule
